// >>> e1rs_status_words.sv
// e1rs_status_words: builds the five receive status bytes of the control
// output stream and sends them in channels 17 to 21 of every frame.
// assumes bit_en is a one-cycle pulse per 2048 khz bit and frame_start
// comes with the bit_en of bit 0 of the frame; status inputs are synchronous.
//
// How it works
// [R1] ch17 bit7: international bit, non-alignment frames
// [R2] ch17 bit6: non-alignment marker bit
// [R3] ch17 bit5: remote alarm bit
// [R4] ch17 bits4-0: national bits
// [R5] ch18 bit7: frame alignment lost flag
// [R6] ch18 bit6: multiframe alignment lost flag
// [R7] ch18 bit5 toggles: 16 errors, 128ms holdoff
// [R8] ch18 bit4 toggles on each buffer slip
// [R9] ch18 bit3: all-ones alarm on line
// [R10] ch18 bit2: all-ones in timeslot 16
// [R11] ch18 bit1: external pin sampled per frame
// [R12] ch19: transmit timeslot and bit phase
// [R13] ch20: wrapping eight-bit crc error counter
// [R14] maintenance clears counter when ch21 bit3 falls
// [R15] ch21 bits7,6: si bits on multiframe pulse
// [R16] ch21 bit3: high 8ms, falls each second
// [R17] ch21 bit2: crc sync missing 8ms after sync
// [R18] ch21 bit1: zero when crc multiframe aligned
// [R19] ch21 bit0: phase ninth bit, toggles on wrap
// [R20] bytes sent msb first in own slot
`timescale 1ns/10ps
`default_nettype none
module e1rs_status_words
  import e1rs_pkg::*;
#(
  parameter logic [E1RS_TIMER_W-1:0] ERR_HOLD_CYC  =
    E1RS_TIMER_W'(E1RS_ERR_HOLD_CYC),
  parameter logic [E1RS_TIMER_W-1:0] SECOND_CYC    =
    E1RS_TIMER_W'(E1RS_SECOND_CYC),
  parameter logic [E1RS_TIMER_W-1:0] CRC_TIMER_CYC =
    E1RS_TIMER_W'(E1RS_CRC_TIMER_CYC),
  parameter logic [E1RS_TIMER_W-1:0] REFRAME_CYC   =
    E1RS_TIMER_W'(E1RS_REFRAME_CYC)
)(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       bit_en,
  input  wire logic       frame_start,
  input  wire logic       nonalign_valid,
  input  wire logic [7:0] nonalign_byte,
  input  wire logic       frame_sync_lost,
  input  wire logic       multiframe_sync_lost,
  input  wire logic       fas_error,
  input  wire logic       slip_event,
  input  wire logic       rx_all_ones_alarm,
  input  wire logic       rx_ts16_all_ones_alarm,
  input  wire logic       external_status_input,
  input  wire logic       tx_8khz_output,
  input  wire logic       crc_error,
  input  wire logic       maintenance_enable,
  input  wire logic       crc_mf_aligned,
  input  wire logic       rx_multiframe_pulse,
  input  wire logic       si_bit_frame15,
  input  wire logic       si_bit_frame13,
  output logic            control_stream_out
);

  // true when the phase word wraps across the frame boundary either way
  function automatic logic phase_wrapped(input logic [7:0] prev,
                                         input logic [7:0] cur);
    phase_wrapped = ((prev[7:6] == 2'b11) && (cur[7:6] == 2'b00)) ||
                    ((prev[7:6] == 2'b00) && (cur[7:6] == 2'b11));
  endfunction : phase_wrapped

  // ---------------- state ----------------
  logic [7:0]    frame_pos,       next_frame_pos;
  logic [7:0]    nonalign_word,   next_nonalign_word;
  logic [7:0]    master_status_one,            next_master_status_one;
  logic [7:0]    phase_word,      next_phase_word;
  logic          phase_msb,       next_phase_msb;
  logic          tx8k_prev,       next_tx8k_prev;
  logic [7:0]    crc_count,       next_crc_count;
  logic          si15,            next_si15;
  logic          si13,            next_si13;
  logic [4:0]    fas_err_count,   next_fas_err_count;
  logic          holdoff_done,    next_holdoff_done;
  logic          err_toggle,      next_err_toggle;
  logic          slip_toggle,     next_slip_toggle;
  logic          ext_sample,      next_ext_sample;
  logic          fsync_lost_prev, next_fsync_lost_prev;
  e1rs_reframe_t rf_state,        next_rf_state;

  logic                    holdoff_restart;
  logic                    holdoff_wrap;
  logic [E1RS_TIMER_W-1:0] second_count;
  logic                    reframe_restart;
  logic                    reframe_wrap;
  logic                    crc_timer_bit;
  logic                    interval_start;
  logic                    sync_found;
  logic                    err_fire;
  logic                    load_slot;
  logic [7:0]              slot_byte;
  logic [7:0]              master_status_two;

  // ---------------- timers ----------------
  e1rs_interval_timer u_holdoff (
    .clk     (clk),
    .rst     (rst),
    .restart (holdoff_restart),
    .limit   (ERR_HOLD_CYC),
    .count   (),
    .wrap    (holdoff_wrap)
  );

  e1rs_interval_timer u_second (
    .clk     (clk),
    .rst     (rst),
    .restart (1'b0),
    .limit   (SECOND_CYC),
    .count   (second_count),
    .wrap    ()
  );

  e1rs_interval_timer u_reframe (
    .clk     (clk),
    .rst     (rst),
    .restart (reframe_restart),
    .limit   (REFRAME_CYC),
    .count   (),
    .wrap    (reframe_wrap)
  );

  // ---------------- status update ----------------
  always_comb begin
    crc_timer_bit   = (second_count < CRC_TIMER_CYC);              // R16
    interval_start  = (second_count == CRC_TIMER_CYC);             // R16
    sync_found      = fsync_lost_prev && !frame_sync_lost;
    err_fire        = (fas_err_count >= E1RS_ERR_THRESHOLD) &&
                      holdoff_done;                                // R7
    holdoff_restart = err_fire;
    reframe_restart = sync_found;

    next_nonalign_word   = nonalign_word;
    next_phase_word      = phase_word;
    next_phase_msb       = phase_msb;
    next_crc_count       = crc_count;
    next_si15            = si15;
    next_si13            = si13;
    next_fas_err_count   = fas_err_count;
    next_holdoff_done    = holdoff_done || holdoff_wrap;
    next_err_toggle      = err_toggle;
    next_slip_toggle     = slip_toggle ^ slip_event;               // R8
    next_ext_sample      = ext_sample;
    next_tx8k_prev       = tx_8khz_output;
    next_fsync_lost_prev = frame_sync_lost;

    if (nonalign_valid) begin
      next_nonalign_word = nonalign_byte;                          // R1
    end

    // error count saturates at the threshold until the toggle fires
    if (err_fire) begin
      next_err_toggle    = !err_toggle;                            // R7
      next_holdoff_done  = 1'b0;
      next_fas_err_count = {4'h0, fas_error};
    end else if (fas_error &&
                 (fas_err_count < E1RS_ERR_THRESHOLD)) begin
      next_fas_err_count = fas_err_count + 5'h01;
    end

    if (bit_en && frame_start) begin
      next_ext_sample = external_status_input;                     // R11
    end

    if (tx_8khz_output && !tx8k_prev) begin
      next_phase_word = frame_pos;                                 // R12
      if (phase_wrapped(phase_word, frame_pos)) begin
        next_phase_msb = !phase_msb;                               // R19
      end
    end

    // an error in the clearing cycle is still counted
    if (interval_start && maintenance_enable) begin
      next_crc_count = {7'h00, crc_error};                         // R14
    end else if (crc_error) begin
      next_crc_count = crc_count + 8'h01;                          // R13
    end

    if (rx_multiframe_pulse) begin
      next_si15 = si_bit_frame15;                                  // R15
      next_si13 = si_bit_frame13;                                  // R15
    end

    next_master_status_one = 8'h00;
    next_master_status_one[E1RS_MASTER_STATUS_ONE_FSYNC]   = frame_sync_lost;                // R5
    next_master_status_one[E1RS_MASTER_STATUS_ONE_MFSYNC]  = multiframe_sync_lost;           // R6
    next_master_status_one[E1RS_MASTER_STATUS_ONE_ERR]     = next_err_toggle;                // R7
    next_master_status_one[E1RS_MASTER_STATUS_ONE_SLIP]    = next_slip_toggle;               // R8
    next_master_status_one[E1RS_MASTER_STATUS_ONE_AIS]     = rx_all_ones_alarm;              // R9
    next_master_status_one[E1RS_MASTER_STATUS_ONE_TS16AIS] = rx_ts16_all_ones_alarm;         // R10
    next_master_status_one[E1RS_MASTER_STATUS_ONE_XS]      = next_ext_sample;                // R11
    next_master_status_one[0]                 = E1RS_UNUSED_BIT;
  end

  // ---------------- reframe watch ----------------
  always_comb begin
    next_rf_state = rf_state;
    case (rf_state)
      E1RS_RF_IDLE: begin
        if (sync_found && maintenance_enable && !crc_mf_aligned) begin
          next_rf_state = E1RS_RF_WAIT;                            // R17
        end
      end
      E1RS_RF_WAIT: begin
        if (crc_mf_aligned || !maintenance_enable || frame_sync_lost) begin
          next_rf_state = E1RS_RF_IDLE;
        end else if (reframe_wrap) begin
          next_rf_state = E1RS_RF_FLAG;                            // R17
        end
      end
      E1RS_RF_FLAG: begin
        if (crc_mf_aligned || !maintenance_enable) begin
          next_rf_state = E1RS_RF_IDLE;                            // R17
        end
      end
      default: begin
        next_rf_state = E1RS_RF_IDLE;
      end
    endcase
  end

  // ---------------- slot selection ----------------
  always_comb begin
    master_status_two = 8'h00;
    master_status_two[E1RS_MASTER_STATUS_TWO_SI15]      = si15;                              // R15
    master_status_two[E1RS_MASTER_STATUS_TWO_SI13]      = si13;                              // R15
    master_status_two[E1RS_MASTER_STATUS_TWO_TIMER]     = crc_timer_bit;                     // R16
    master_status_two[E1RS_MASTER_STATUS_TWO_REFRAME]   = (rf_state == E1RS_RF_FLAG);        // R17
    master_status_two[E1RS_MASTER_STATUS_TWO_CRC_SYNC_FLAG]   = !crc_mf_aligned;                   // R18
    master_status_two[E1RS_MASTER_STATUS_TWO_PHASE_MSB] = phase_msb;                         // R19

    if (bit_en) begin
      next_frame_pos = frame_start ? 8'h00 : frame_pos + 8'h01;
    end else begin
      next_frame_pos = frame_pos;
    end
    load_slot = bit_en && (next_frame_pos[2:0] == 3'h0);

    if (next_frame_pos[7:3] == E1RS_CH_NONALIGN) begin
      slot_byte = nonalign_word;                                   // R2 R3 R4
    end else if (next_frame_pos[7:3] == E1RS_CH_MASTER_STATUS_ONE) begin
      slot_byte = master_status_one;
    end else if (next_frame_pos[7:3] == E1RS_CH_PHASE) begin
      slot_byte = phase_word;
    end else if (next_frame_pos[7:3] == E1RS_CH_CRC_COUNT) begin
      slot_byte = crc_count;
    end else if (next_frame_pos[7:3] == E1RS_CH_MASTER_STATUS_TWO) begin
      slot_byte = master_status_two;
    end else begin
      slot_byte = E1RS_IDLE_BYTE;
    end
  end

  e1rs_serializer u_ser (
    .clk        (clk),
    .rst        (rst),
    .shift_en   (bit_en),
    .load       (load_slot),
    .load_byte  (slot_byte),
    .serial_out (control_stream_out)                               // R20
  );

  // ---------------- registers ----------------
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_pos       <= E1RS_RESET_BYTE;
      nonalign_word   <= E1RS_NONALIGN_RESET;
      master_status_one            <= E1RS_RESET_BYTE;
      phase_word      <= E1RS_RESET_BYTE;
      phase_msb       <= 1'b0;
      tx8k_prev       <= 1'b0;
      crc_count       <= E1RS_RESET_BYTE;
      si15            <= 1'b0;
      si13            <= 1'b0;
      fas_err_count   <= 5'h00;
      holdoff_done    <= 1'b1;
      err_toggle      <= 1'b0;
      slip_toggle     <= 1'b0;
      ext_sample      <= 1'b0;
      fsync_lost_prev <= 1'b0;
      rf_state        <= E1RS_RF_IDLE;
    end else begin
      frame_pos       <= next_frame_pos;
      nonalign_word   <= next_nonalign_word;
      master_status_one            <= next_master_status_one;
      phase_word      <= next_phase_word;
      phase_msb       <= next_phase_msb;
      tx8k_prev       <= next_tx8k_prev;
      crc_count       <= next_crc_count;
      si15            <= next_si15;
      si13            <= next_si13;
      fas_err_count   <= next_fas_err_count;
      holdoff_done    <= next_holdoff_done;
      err_toggle      <= next_err_toggle;
      slip_toggle     <= next_slip_toggle;
      ext_sample      <= next_ext_sample;
      fsync_lost_prev <= next_fsync_lost_prev;
      rf_state        <= next_rf_state;
    end
  end

endmodule : e1rs_status_words
`default_nettype wire

// >>> e1rs_pkg.sv
// e1rs_pkg: constants for the e1 receive status words block
// assumes a 100 mhz system clock and a 2048 khz bit enable from outside
package e1rs_pkg;

  localparam int unsigned E1RS_CLK_KHZ        = 100000;
  localparam int unsigned E1RS_TIMER_W        = 27;

  // times in milliseconds, counts in clock cycles
  localparam int unsigned E1RS_ERR_HOLD_MS    = 128;
  localparam int unsigned E1RS_SECOND_MS      = 1000;
  localparam int unsigned E1RS_CRC_TIMER_MS   = 8;
  localparam int unsigned E1RS_REFRAME_MS     = 8;
  localparam int unsigned E1RS_ERR_HOLD_CYC   = E1RS_CLK_KHZ * E1RS_ERR_HOLD_MS;
  localparam int unsigned E1RS_SECOND_CYC     = E1RS_CLK_KHZ * E1RS_SECOND_MS;
  localparam int unsigned E1RS_CRC_TIMER_CYC  = E1RS_CLK_KHZ * E1RS_CRC_TIMER_MS;
  localparam int unsigned E1RS_REFRAME_CYC    = E1RS_CLK_KHZ * E1RS_REFRAME_MS;

  // control stream channel slots
  localparam logic [4:0] E1RS_CH_NONALIGN     = 5'h11;
  localparam logic [4:0] E1RS_CH_MASTER_STATUS_ONE         = 5'h12;
  localparam logic [4:0] E1RS_CH_PHASE        = 5'h13;
  localparam logic [4:0] E1RS_CH_CRC_COUNT    = 5'h14;
  localparam logic [4:0] E1RS_CH_MASTER_STATUS_TWO         = 5'h15;

  // master status one field positions
  localparam int unsigned E1RS_MASTER_STATUS_ONE_FSYNC     = 7;
  localparam int unsigned E1RS_MASTER_STATUS_ONE_MFSYNC    = 6;
  localparam int unsigned E1RS_MASTER_STATUS_ONE_ERR       = 5;
  localparam int unsigned E1RS_MASTER_STATUS_ONE_SLIP      = 4;
  localparam int unsigned E1RS_MASTER_STATUS_ONE_AIS       = 3;
  localparam int unsigned E1RS_MASTER_STATUS_ONE_TS16AIS   = 2;
  localparam int unsigned E1RS_MASTER_STATUS_ONE_XS        = 1;

  // master status two field positions
  localparam int unsigned E1RS_MASTER_STATUS_TWO_SI15      = 7;
  localparam int unsigned E1RS_MASTER_STATUS_TWO_SI13      = 6;
  localparam int unsigned E1RS_MASTER_STATUS_TWO_TIMER     = 3;
  localparam int unsigned E1RS_MASTER_STATUS_TWO_REFRAME   = 2;
  localparam int unsigned E1RS_MASTER_STATUS_TWO_CRC_SYNC_FLAG   = 1;
  localparam int unsigned E1RS_MASTER_STATUS_TWO_PHASE_MSB = 0;

  // fixed values
  localparam logic       E1RS_UNUSED_BIT      = 1'b0;
  localparam logic [7:0] E1RS_IDLE_BYTE       = 8'hff;
  localparam logic [4:0] E1RS_ERR_THRESHOLD   = 5'h10;
  localparam logic [7:0] E1RS_RESET_BYTE      = 8'h00;
  localparam logic [7:0] E1RS_NONALIGN_RESET  = 8'h7f;

  typedef enum logic [2:0] {
    E1RS_RF_IDLE = 3'b001,
    E1RS_RF_WAIT = 3'b010,
    E1RS_RF_FLAG = 3'b100
  } e1rs_reframe_t;

endpackage : e1rs_pkg

// >>> e1rs_interval_timer.sv
// e1rs_interval_timer: cycle counter that wraps at a given limit
// assumes limit is at least 1; restart forces the count back to zero
`timescale 1ns/10ps
`default_nettype none
module e1rs_interval_timer
  import e1rs_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    restart,
  input  wire logic [E1RS_TIMER_W-1:0] limit,
  output logic      [E1RS_TIMER_W-1:0] count,
  output logic                         wrap
);

  logic [E1RS_TIMER_W-1:0] next_count;

  always_comb begin
    wrap = (count == limit - 1'b1);
    if (restart || wrap) begin
      next_count = '0;
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule : e1rs_interval_timer
`default_nettype wire

// >>> e1rs_serializer.sv
// e1rs_serializer: shifts one byte out msb first, one bit per bit enable
// assumes load only ever comes together with shift_en
`timescale 1ns/10ps
`default_nettype none
module e1rs_serializer
  import e1rs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       shift_en,
  input  wire logic       load,
  input  wire logic [7:0] load_byte,
  output logic            serial_out
);

  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic       next_out;

  always_comb begin
    next_shreg = shreg;
    next_out   = serial_out;
    if (shift_en) begin
      if (load) begin
        next_out   = load_byte[7];
        next_shreg = {load_byte[6:0], 1'b1};
      end else begin
        next_out   = shreg[7];
        next_shreg = {shreg[6:0], 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shreg      <= E1RS_IDLE_BYTE;
      serial_out <= 1'b1;
    end else begin
      shreg      <= next_shreg;
      serial_out <= next_out;
    end
  end

endmodule : e1rs_serializer
`default_nettype wire

// >>> e1rs_status_words_checker.sv
// e1rs_status_words_checker: assertions on the control output stream
// assumes frame_start comes with the bit_en of bit 0 of each frame
`timescale 1ns/10ps
`default_nettype none
module e1rs_status_words_checker #(
  parameter int unsigned SECOND_CYC    = 400,
  parameter int unsigned CRC_TIMER_CYC = 20
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_en,
  input wire logic frame_start,
  input wire logic frame_sync_lost,
  input wire logic multiframe_sync_lost,
  input wire logic rx_all_ones_alarm,
  input wire logic rx_ts16_all_ones_alarm,
  input wire logic external_status_input,
  input wire logic crc_mf_aligned,
  input wire logic control_stream_out
);
  logic       d_en;
  logic [7:0] pos;
  logic [7:0] next_pos;
  logic [7:0] d_pos;
  logic [6:0] snap;
  logic       out;
  int unsigned sec;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  assign out = control_stream_out;
  assign next_pos = frame_start ? 8'h00 : pos + 8'h01;

  // d_pos is the slot whose bit shows on the output while d_en is high;
  // alarm and sync snapshots are taken a bit time before channels 18 and 21 are loaded
  always_ff @(posedge clk) begin
    if (rst) begin
      d_en <= 1'b0;
      pos <= 8'h00;
      d_pos <= 8'h00;
      snap <= 7'h00;
      sec <= 0;
    end else begin
      d_en <= bit_en;
      // one-second interval runs free from reset; its timer bit is taken
      // at the edge that loads channel 21
      sec <= (sec == SECOND_CYC - 1) ? 0 : sec + 1;
      if (bit_en && next_pos == 8'ha8) begin
        snap[6] <= (sec < CRC_TIMER_CYC);
      end
      if (bit_en) begin
        pos <= next_pos;
        d_pos <= next_pos;
      end
      if (d_en && d_pos == 8'h8f) begin
        snap[3:0] <= {rx_ts16_all_ones_alarm, rx_all_ones_alarm,
                      multiframe_sync_lost, frame_sync_lost};
      end
      if (bit_en && frame_start) begin
        snap[4] <= external_status_input;
      end
      if (d_en && d_pos == 8'ha7) begin
        snap[5] <= crc_mf_aligned;
      end
    end
  end

  a_out_stable: assert property (!$past(bit_en) |-> $stable(out))
    else $error("output moved without a bit enable");
  a_idle_chan: assert property (d_en && (d_pos[7:3] < 5'h11 ||
    d_pos[7:3] > 5'h15) |-> out) else $error("idle slot not high");
  a_unused_bits: assert property (d_en &&
    (d_pos == 8'h97 || d_pos == 8'haa || d_pos == 8'hab) |-> !out)
    else $error("unused status bit not low");
  a_fsync_bit: assert property (d_en && d_pos == 8'h90 |->
    out == snap[0]) else $error("frame sync lost bit wrong");
  a_mfsync_bit: assert property (d_en && d_pos == 8'h91 |->
    out == snap[1]) else $error("multiframe sync lost bit wrong");
  a_ais_bit: assert property (d_en && d_pos == 8'h94 |-> out == snap[2])
    else $error("all ones alarm bit wrong");
  a_ts16_bit: assert property (d_en && d_pos == 8'h95 |->
    out == snap[3]) else $error("timeslot 16 alarm bit wrong");
  a_xs_bit: assert property (d_en && d_pos == 8'h96 |-> out == snap[4])
    else $error("external status bit wrong");
  a_crc_sync_bit: assert property (d_en && d_pos == 8'hae |->
    out != snap[5]) else $error("crc sync bit wrong");
  a_timer_bit: assert property (d_en && d_pos == 8'hac |->
    out == snap[6]) else $error("crc timer bit wrong");
endmodule : e1rs_status_words_checker

bind e1rs_status_words e1rs_status_words_checker #(.SECOND_CYC(SECOND_CYC),
  .CRC_TIMER_CYC(CRC_TIMER_CYC)) e1rs_status_words_checker_inst (
  .clk(clk), .rst(rst), .bit_en(bit_en), .frame_start(frame_start),
  .frame_sync_lost(frame_sync_lost),
  .multiframe_sync_lost(multiframe_sync_lost),
  .rx_all_ones_alarm(rx_all_ones_alarm),
  .rx_ts16_all_ones_alarm(rx_ts16_all_ones_alarm),
  .external_status_input(external_status_input),
  .crc_mf_aligned(crc_mf_aligned), .control_stream_out(control_stream_out));
`default_nettype wire

// >>> e1rs_ctrl_reader.sv
// e1rs_ctrl_reader: controller model that reads the control output stream
// assumes the same bit enable and frame start as the device
`timescale 1ns/10ps
`default_nettype none
module e1rs_ctrl_reader (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       bit_en,
  input  wire logic       frame_start,
  input  wire logic       serial_in,
  output logic      [7:0] got [32],
  output logic      [7:0] frame_cnt
);
  logic       d_en;
  logic [7:0] pos;
  logic [7:0] d_pos;
  logic [6:0] sh;

  always_ff @(posedge clk) begin
    if (rst) begin
      d_en <= 1'b0;
      pos <= 8'h00;
      d_pos <= 8'h00;
      sh <= 7'h00;
      frame_cnt <= 8'h00;
    end else begin
      d_en <= bit_en;
      if (bit_en) begin
        pos <= frame_start ? 8'h00 : pos + 8'h01;
        d_pos <= frame_start ? 8'h00 : pos + 8'h01;
      end
      if (d_en) begin
        sh <= {sh[5:0], serial_in};
        if (d_pos[2:0] == 3'h7) begin
          got[d_pos[7:3]] <= {sh, serial_in};
        end
        if (d_pos == 8'hff) begin
          frame_cnt <= frame_cnt + 8'h01;
        end
      end
    end
  end
endmodule : e1rs_ctrl_reader
`default_nettype wire

// >>> e1rs_status_words_tb.sv
// e1rs_status_words_tb: scenario bench for the receive status words
// assumes a bit every 4 clocks, which keeps frames short in simulation
`timescale 1ns/10ps
`default_nettype none
module e1rs_status_words_tb
  import e1rs_pkg::*;
;
  logic       clk, rst, bit_en, frame_start, out;
  logic       fsl, mfl, ais, ts16, xs, tx8k, maint, crcal, si15, si13;
  logic [4:0] pl;
  logic [7:0] nab, tp, frame_cnt;
  logic [1:0] ph;
  logic [7:0] got [32];
  int         n_fail, samples_checked;

  e1rs_status_words #(.ERR_HOLD_CYC(27'd200), .SECOND_CYC(27'd400),
    .CRC_TIMER_CYC(27'd20), .REFRAME_CYC(27'd30)) e1rs_status_words_inst (
    .clk(clk), .rst(rst), .bit_en(bit_en), .frame_start(frame_start),
    .nonalign_valid(pl[4]), .nonalign_byte(nab), .frame_sync_lost(fsl),
    .multiframe_sync_lost(mfl), .fas_error(pl[0]), .slip_event(pl[1]),
    .rx_all_ones_alarm(ais), .rx_ts16_all_ones_alarm(ts16),
    .external_status_input(xs), .tx_8khz_output(tx8k), .crc_error(pl[2]),
    .maintenance_enable(maint), .crc_mf_aligned(crcal),
    .rx_multiframe_pulse(pl[3]), .si_bit_frame15(si15),
    .si_bit_frame13(si13), .control_stream_out(out));
  e1rs_ctrl_reader e1rs_ctrl_reader_inst (.clk(clk), .rst(rst),
    .bit_en(bit_en), .frame_start(frame_start), .serial_in(out),
    .got(got), .frame_cnt(frame_cnt));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    #1;
    ph = rst ? 2'h0 : ph + 2'h1;
    bit_en = !rst && ph == 2'h0;
    if (rst) tp = 8'hff;
    else if (bit_en) tp = tp + 8'h01;
    frame_start = bit_en && tp == 8'h00;
  end

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      n_fail++;
      $display("[FAIL] %0t wait ran out", $time);
      summarize();
    end
  endtask : guard

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tick

  // returns just after a whole frame has been read back
  task automatic wait_frame();
    logic [7:0] f0;
    int         k;
    f0 = frame_cnt;
    k = 0;
    while (frame_cnt === f0 && k < 3000) begin
      tick(1);
      k++;
    end
    guard(k, 3000);
  endtask : wait_frame

  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      pl[idx] = 1'b1;
      tick(1);
      pl[idx] = 1'b0;
      tick(1);
    end
  endtask : pulse

  task automatic t_reset();
    wait_frame();
    chk(got[17], E1RS_NONALIGN_RESET);
    chk(got[18], 8'h00);
    chk(got[19], 8'h00);
    chk(got[20], 8'h00);
    chk(got[0], E1RS_IDLE_BYTE);
  endtask : t_reset

  task automatic t_nonalign();
    logic [7:0] v [4] = '{8'h80, 8'h40, 8'h20, 8'h1f};
    for (int i = 0; i < 4; i++) begin
      nab = v[i];
      pulse(4, 1);
      nab = ~v[i];
      wait_frame();
      chk(got[17], v[i]);
    end
  endtask : t_nonalign

  task automatic t_levels();
    for (int i = 0; i < 6; i++) begin
      {fsl, mfl, ais, ts16, xs} = 5'h10 >> i;
      wait_frame();
      chk(got[18], {fsl, mfl, 2'b00, ais, ts16, xs, 1'b0});
    end
  endtask : t_levels

  task automatic t_err();
    pulse(1, 3);
    wait_frame();
    chk(8'(got[18][4]), 8'h01);
    pulse(0, 16);
    wait_frame();
    chk(8'(got[18][5]), 8'h01);
    pulse(0, 15);
    wait_frame();
    chk(8'(got[18][5]), 8'h01);
    pulse(0, 1);
    wait_frame();
    chk(8'(got[18][5]), 8'h00);
    // second toggle must wait out the holdoff past this frame's load
    tick(400);
    pulse(0, 32);
    wait_frame();
    chk(8'(got[18][5]), 8'h01);
    wait_frame();
    chk(8'(got[18][5]), 8'h00);
  endtask : t_err

  task automatic t_phase();
    logic [7:0] p [5] = '{8'h2b, 8'he0, 8'h80, 8'h10, 8'hc8};
    logic       m [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    int         k;
    for (int i = 0; i < 5; i++) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (!(bit_en && tp == p[i]) && k < 1100);
      guard(k, 1100);
      #1 tx8k = 1'b1;
      tick(2);
      tx8k = 1'b0;
      wait_frame();
      wait_frame();
      chk(got[19], p[i]);
      chk(8'(got[21][0]), 8'(m[i]));
    end
  endtask : t_phase

  task automatic t_crc();
    pulse(2, 257);
    wait_frame();
    chk(got[20], 8'h01);
    maint = 1'b1;
    pulse(2, 3);
    wait_frame();
    chk(got[20], 8'h00);
  endtask : t_crc

  task automatic t_reframe();
    for (int i = 0; i < 2; i++) begin
      fsl = 1'b1;
      tick(2);
      fsl = 1'b0;
      wait_frame();
      chk(8'(got[21][2:1]), 8'h03);
      crcal = (i == 0);
      maint = (i == 0);
      wait_frame();
      chk(8'(got[21][2:1]), i == 0 ? 8'h00 : 8'h01);
      crcal = 1'b0;
      maint = 1'b1;
    end
  endtask : t_reframe

  task automatic t_si();
    {si15, si13} = 2'b10;
    pulse(3, 1);
    {si15, si13} = 2'b01;
    wait_frame();
    chk(8'(got[21][7:6]), 8'h02);
    pulse(3, 1);
    wait_frame();
    chk(8'(got[21][7:6]), 8'h01);
  endtask : t_si

  initial begin
    {clk, fsl, mfl, ais, ts16, xs} = '0;
    {tx8k, maint, crcal, si15, si13, pl, nab} = '0;
    rst = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_nonalign();
    t_levels();
    t_err();
    t_phase();
    t_crc();
    t_reframe();
    t_si();
    summarize();
  end
endmodule : e1rs_status_words_tb
`default_nettype wire
